// File: rtl/acs_clock_regs.sv
// apb register block with clock-setting decode for the audio receiver
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module acs_clock_regs #(
	parameter int          APB_ADDR_W  = 12,
	parameter logic [15:0] DEVICE_INFO = 16'h0000 // arbitrary value
) (
	input  wire logic                       clk_i,
	input  wire logic                       sys_rst_i,
	input  wire logic                       ce_i,
	input  wire logic                       psel_i,
	input  wire logic                       penable_i,
	input  wire logic                       pwrite_i,
	input  wire logic [APB_ADDR_W-1:0]      paddr_i,
	input  wire logic [31:0]                pwdata_i,
	input  wire logic [3:0]                 pstrb_i,
	output logic                            pready_o,
	output logic [31:0]                     prdata_o,
	output logic                            pslverr_o,
	input  wire logic [acs_pkg::REG_W-1:0]  interp_status_i,
	input  wire logic [acs_pkg::REG_W-1:0]  digital_input_status_i,
	input  wire logic [acs_pkg::REG_W-1:0]  loop_status_i,
	input  wire logic [39:0]                chan_status_left_i,
	input  wire logic [39:0]                chan_status_right_i,
	input  wire logic                       recovered_clk_i,
	input  wire logic                       xtal_clk_i,
	output logic [1:0]                      crystal_divider_sel_o,
	output logic [9:0]                      xtal_fs_mult_o,
	output logic [3:0]                      dac_div_ratio_o,
	output logic [6:0]                      dac_fs_mult_o,
	output logic                            synth_source_sel_o,
	output logic                            synth_mode_enable_o,
	output logic [2:0]                      prescaler_ratio_sel_o,
	output logic [10:0]                     prescaler_ratio_o,
	output logic                            prescaler_reserved_o,
	output logic                            clock_output_source_sel_o,
	output logic                            clock_output_pin_o,
	output logic [acs_pkg::REG_W-1:0]       serial_output_settings_o,
	output logic [acs_pkg::REG_W-1:0]       serial_input_settings_o,
	output logic [acs_pkg::REG_W-1:0]       power_down_settings_o,
	output logic [acs_pkg::REG_W-1:0]       volume_left_right_o,
	output logic [acs_pkg::REG_W-1:0]       sound_feature_tone_o,
	output logic [acs_pkg::REG_W-1:0]       deemphasis_mute_o,
	output logic [acs_pkg::REG_W-1:0]       dac_source_clock_o,
	output logic [acs_pkg::REG_W-1:0]       digital_input_settings_o,
	output logic [acs_pkg::REG_W-1:0]       supplemental_settings_o,
	output logic [acs_pkg::REG_W-1:0]       loop_coarse_ratio_o
);
	import acs_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// elaboration checks

	// index field sits in paddr[8:2], so narrower buses cannot reach 7FH
	if (APB_ADDR_W < 9 || APB_ADDR_W > 32) begin : g_bad_addr_w
		$error("APB_ADDR_W must lie between 9 and 32");
	end

	//////////////////////////////////////////////////////////////////////////
	// declarations

	acs_apb_e           state;
	logic [15:0]        ctrl_q [NUM_CTRL];
	logic [15:0]        coarse_q;
	logic [SYNC_W-1:0]  pin_raw;
	logic [SYNC_W-1:0]  sync1;
	logic [SYNC_W-1:0]  sync2;
	logic [SYNC_W-1:0]  sync3;
	logic [SYNC_W-1:0]  pin_q;
	logic [IDX_W-1:0]   acc_idx;
	logic               acc_aligned;
	logic               hit_ctrl;
	logic               hit_coarse;
	logic               hit_swrst;
	logic               hit_status;
	logic               addr_valid;
	logic [15:0]        rd_word;
	logic               commit;
	logic               wr_commit;
	logic               swrst_commit;
	logic [15:0]        wdata_lanes_next [NUM_CTRL];
	logic [15:0]        coarse_lanes_next;

	//////////////////////////////////////////////////////////////////////////
	// input synchronisers

	// all status words and both sampled clocks cross from outside the domain
	assign pin_raw = {xtal_clk_i, recovered_clk_i, chan_status_right_i,
		chan_status_left_i, loop_status_i, digital_input_status_i,
		interp_status_i};

	// three stages per bit; a change is taken once stages two and three agree
	for (genvar b = 0; b < SYNC_W; b++) begin : g_sync
		always_ff @(posedge clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				sync1[b] <= 1'b0;
				sync2[b] <= 1'b0;
				sync3[b] <= 1'b0;
				pin_q[b] <= 1'b0;
			end else if (ce_i) begin
				sync1[b] <= pin_raw[b];
				sync2[b] <= sync1[b];
				sync3[b] <= sync2[b];
				if (sync2[b] == sync3[b]) begin
					pin_q[b] <= sync3[b];
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// address decode

	// misaligned or out-of-range byte addresses never hit a register
	always_comb begin
		acc_idx     = paddr_i[8:2];
		acc_aligned = (paddr_i[1:0] == 2'h0);
		if (APB_ADDR_W > 9) begin
			acc_aligned = acc_aligned && ((paddr_i >> 9) == '0);
		end
		hit_ctrl = 1'b0;
		for (int i = 0; i < NUM_CTRL; i++) begin
			if (acc_idx == CTRL_IDX[i]) begin
				hit_ctrl = 1'b1;
			end
		end
		hit_coarse = (acc_idx == IDX_COARSE);
		hit_swrst  = (acc_idx == IDX_SWRST);
		unique case (acc_idx)
			IDX_INTERP, IDX_DIGSTAT, IDX_LOOPST, IDX_DEVINFO,
			IDX_CS_L0, IDX_CS_L1, IDX_CS_L2,
			IDX_CS_R0, IDX_CS_R1, IDX_CS_R2: hit_status = 1'b1;
			default: hit_status = 1'b0;
		endcase
		addr_valid = acc_aligned &&
			(hit_ctrl || hit_coarse || hit_swrst || hit_status);
	end

	// read view; write-only registers read as zero
	always_comb begin
		unique case (acc_idx)
			IDX_INTERP:  rd_word = pin_q[15:0];
			IDX_DIGSTAT: rd_word = pin_q[31:16];
			IDX_LOOPST:  rd_word = pin_q[47:32];
			IDX_CS_L0:   rd_word = pin_q[63:48];
			IDX_CS_L1:   rd_word = pin_q[79:64];
			IDX_CS_L2:   rd_word = {8'h00, pin_q[87:80]};
			IDX_CS_R0:   rd_word = pin_q[103:88];
			IDX_CS_R1:   rd_word = pin_q[119:104];
			IDX_CS_R2:   rd_word = {8'h00, pin_q[127:120]};
			IDX_DEVINFO: rd_word = DEVICE_INFO;
			default:     rd_word = 16'h0000;
		endcase
		if (!acc_aligned) begin
			rd_word = 16'h0000;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// apb handshake

	// the write lands on the edge that samples pready high, never earlier
	assign commit       = (state == ACS_ANSWER) && psel_i && penable_i;
	assign wr_commit    = commit && pwrite_i && acc_aligned;
	assign swrst_commit = wr_commit && hit_swrst;

	// one wait state: answer is prepared, then held for the completing edge
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state     <= ACS_IDLE;
			pready_o  <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else if (ce_i) begin
			unique case (state)
				ACS_IDLE: begin
					if (psel_i && penable_i) begin
						state     <= ACS_ANSWER;
						pready_o  <= 1'b1;
						pslverr_o <= !addr_valid;
						prdata_o  <= pwrite_i ? 32'h0000_0000 : {16'h0000, rd_word};
					end
				end
				ACS_ANSWER: begin
					state     <= ACS_IDLE;
					pready_o  <= 1'b0;
					pslverr_o <= 1'b0;
					prdata_o  <= 32'h0000_0000;
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// control registers

	// byte strobes pick lanes; unimplemented bits never store
	for (genvar g = 0; g < NUM_CTRL; g++) begin : g_ctrl
		always_comb begin
			wdata_lanes_next[g][15:8] = pstrb_i[1] ? pwdata_i[15:8] : ctrl_q[g][15:8];
			wdata_lanes_next[g][7:0]  = pstrb_i[0] ? pwdata_i[7:0] : ctrl_q[g][7:0];
			wdata_lanes_next[g]       = wdata_lanes_next[g] & CTRL_MASK[g];
		end

		always_ff @(posedge clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				ctrl_q[g] <= CTRL_RST[g];
			end else if (ce_i) begin
				if (swrst_commit) begin
					ctrl_q[g] <= CTRL_RST[g];
				end else if (wr_commit && acc_idx == CTRL_IDX[g]) begin
					ctrl_q[g] <= wdata_lanes_next[g];
				end
			end
		end
	end

	// coarse ratio has no defined bit layout, so all sixteen bits store
	always_comb begin
		coarse_lanes_next[15:8] = pstrb_i[1] ? pwdata_i[15:8] : coarse_q[15:8];
		coarse_lanes_next[7:0]  = pstrb_i[0] ? pwdata_i[7:0] : coarse_q[7:0];
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			coarse_q <= LOOP_COARSE_RST;
		end else if (ce_i) begin
			if (swrst_commit) begin
				coarse_q <= LOOP_COARSE_RST;
			end else if (wr_commit && hit_coarse) begin
				coarse_q <= coarse_lanes_next;
			end
		end
	end

	// other settings go straight out from their flip-flops
	assign serial_output_settings_o = ctrl_q[1];
	assign serial_input_settings_o  = ctrl_q[2];
	assign power_down_settings_o    = ctrl_q[3];
	assign volume_left_right_o      = ctrl_q[4];
	assign sound_feature_tone_o     = ctrl_q[5];
	assign deemphasis_mute_o        = ctrl_q[6];
	assign dac_source_clock_o       = ctrl_q[7];
	assign digital_input_settings_o = ctrl_q[8];
	assign supplemental_settings_o  = ctrl_q[9];
	assign loop_coarse_ratio_o      = coarse_q;

	//////////////////////////////////////////////////////////////////////////
	// clock-setting decode

	// crystal ratio 1:2..1:8 and crystal clock 128..512 fs; dac at 64 fs
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			crystal_divider_sel_o <= 2'h0;
			xtal_fs_mult_o        <= XTAL_FS_UNIT;
			dac_div_ratio_o       <= 4'h2;
			dac_fs_mult_o         <= DAC_FS_MULT;
		end else if (ce_i) begin
			crystal_divider_sel_o <= ctrl_q[0][XDIV_LSB+:2];
			xtal_fs_mult_o        <= XTAL_FS_UNIT * (10'(ctrl_q[0][XDIV_LSB+:2]) + 10'h1);
			dac_div_ratio_o       <= {ctrl_q[0][XDIV_LSB+:2], 1'b0} + 4'h2;
			dac_fs_mult_o         <= DAC_FS_MULT;
		end
	end

	// synthesizer source and enable follow their bits directly
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			synth_source_sel_o  <= 1'b0;
			synth_mode_enable_o <= 1'b0;
		end else if (ce_i) begin
			synth_source_sel_o  <= ctrl_q[0][SRC_BIT];
			synth_mode_enable_o <= ctrl_q[0][SYN_EN_BIT];
		end
	end

	// ratio only meaningful while the synthesizer runs; reserved codes give 0
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prescaler_ratio_sel_o <= 3'h0;
			prescaler_ratio_o     <= 11'h000;
			prescaler_reserved_o  <= 1'b0;
		end else if (ce_i) begin
			prescaler_ratio_sel_o <= ctrl_q[0][PRE_LSB+:3];
			prescaler_reserved_o  <= ctrl_q[0][PRE_LSB+2];
			if (!ctrl_q[0][SYN_EN_BIT]) begin
				prescaler_ratio_o <= 11'h000;
			end else begin
				unique case (ctrl_q[0][PRE_LSB+:3])
					3'h0:    prescaler_ratio_o <= PRE_R0;
					3'h1:    prescaler_ratio_o <= PRE_R1;
					3'h2:    prescaler_ratio_o <= PRE_R2;
					3'h3:    prescaler_ratio_o <= PRE_R3;
					default: prescaler_ratio_o <= 11'h000;
				endcase
			end
		end
	end

	// sampled clocks only; faithful only well below half the 10 MHz rate
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			clock_output_source_sel_o <= 1'b0;
			clock_output_pin_o        <= 1'b0;
		end else if (ce_i) begin
			clock_output_source_sel_o <= ctrl_q[0][CKOUT_BIT];
			clock_output_pin_o        <= ctrl_q[0][CKOUT_BIT] ? pin_q[129] : pin_q[128];
		end
	end

endmodule : acs_clock_regs

// File: rtl/acs_pkg.sv
// constants, register map and field layout of the clock-setting register block
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package acs_pkg;
	localparam int          REG_W      = 16;
	localparam int          IDX_W      = 7;
	localparam int          NUM_CTRL   = 10;
	localparam int          SYNC_W     = 130;
	// register indices; byte address is four times the index
	localparam logic [6:0] IDX_CLOCK   = 7'h00;
	localparam logic [6:0] IDX_SER_OUT = 7'h01;
	localparam logic [6:0] IDX_SER_IN  = 7'h02;
	localparam logic [6:0] IDX_POWER   = 7'h03;
	localparam logic [6:0] IDX_VOLUME  = 7'h10;
	localparam logic [6:0] IDX_TONE    = 7'h12;
	localparam logic [6:0] IDX_DEEMPH  = 7'h13;
	localparam logic [6:0] IDX_DACSRC  = 7'h14;
	localparam logic [6:0] IDX_INTERP  = 7'h18;
	localparam logic [6:0] IDX_DIGIN   = 7'h30;
	localparam logic [6:0] IDX_SUPPL   = 7'h40;
	localparam logic [6:0] IDX_DIGSTAT = 7'h59;
	localparam logic [6:0] IDX_CS_L0   = 7'h5A;
	localparam logic [6:0] IDX_CS_L1   = 7'h5B;
	localparam logic [6:0] IDX_CS_L2   = 7'h5C;
	localparam logic [6:0] IDX_CS_R0   = 7'h5D;
	localparam logic [6:0] IDX_CS_R1   = 7'h5E;
	localparam logic [6:0] IDX_CS_R2   = 7'h5F;
	localparam logic [6:0] IDX_COARSE  = 7'h62;
	localparam logic [6:0] IDX_LOOPST  = 7'h68;
	localparam logic [6:0] IDX_DEVINFO = 7'h7E;
	localparam logic [6:0] IDX_SWRST   = 7'h7F;
	// writable registers: index, reset value, implemented-bit mask
	localparam logic [6:0] CTRL_IDX [NUM_CTRL] = '{IDX_CLOCK, IDX_SER_OUT, IDX_SER_IN,
		IDX_POWER, IDX_VOLUME, IDX_TONE, IDX_DEEMPH, IDX_DACSRC, IDX_DIGIN, IDX_SUPPL};
	localparam logic [15:0] CTRL_RST [NUM_CTRL] = '{16'h0000, 16'h0000, 16'h0000,
		16'h2013, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	localparam logic [15:0] CTRL_MASK [NUM_CTRL] = '{16'h039F, 16'h0187, 16'h0007,
		16'h3013, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
	localparam logic [15:0] LOOP_COARSE_RST = 16'h0000;
	// clock register field positions
	localparam int          XDIV_LSB   = 8;
	localparam int          SRC_BIT    = 7;
	localparam int          PRE_LSB    = 2;
	localparam int          CKOUT_BIT  = 1;
	localparam int          SYN_EN_BIT = 0;
	// ratios and sample-rate multiples
	localparam logic [10:0] PRE_R0     = 11'h024;
	localparam logic [10:0] PRE_R1     = 11'h271;
	localparam logic [10:0] PRE_R2     = 11'h280;
	localparam logic [10:0] PRE_R3     = 11'h465;
	localparam logic [9:0]  XTAL_FS_UNIT = 10'h080;
	localparam logic [6:0]  DAC_FS_MULT  = 7'h40;
	typedef enum logic [0:0] {ACS_IDLE = 1'b0, ACS_ANSWER = 1'b1} acs_apb_e;
endpackage : acs_pkg

// File: tb/acs_clock_regs_checker.sv
// assertion checker for the clock-setting register block
`timescale 1ns/1ps
module acs_clock_regs_checker #(
	parameter int APB_ADDR_W = 12
) (
	input wire logic                  clk_i,
	input wire logic                  sys_rst_i,
	input wire logic                  ce_i,
	input wire logic                  psel_i,
	input wire logic                  penable_i,
	input wire logic                  pwrite_i,
	input wire logic [APB_ADDR_W-1:0] paddr_i,
	input wire logic                  pready_o,
	input wire logic [31:0]           prdata_o,
	input wire logic                  pslverr_o,
	input wire logic [9:0]            xtal_fs_mult_o,
	input wire logic [3:0]            dac_div_ratio_o,
	input wire logic [6:0]            dac_fs_mult_o,
	input wire logic                  synth_mode_enable_o,
	input wire logic [2:0]            prescaler_ratio_sel_o,
	input wire logic [10:0]           prescaler_ratio_o
);
	import acs_pkg::*;
	logic acc;
	// an access phase not yet answered
	assign acc = psel_i && penable_i && ce_i && !pready_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// ratio only counts while the synthesizer runs and the code is defined
	function automatic logic [10:0] pre_of(input logic en, input logic [2:0] c);
		if (!en || c[2]) return 11'h000;
		case (c[1:0])
			2'h0: return 11'h024;
			2'h1: return 11'h271;
			2'h2: return 11'h280;
			default: return 11'h465;
		endcase
	endfunction : pre_of
	////////////////////////////////////////
	property p_fs; xtal_fs_mult_o == {dac_div_ratio_o, 6'h00}; endproperty
	a_fs: assert property (p_fs) else $error("crystal multiple off divider");
	property p_dfs; dac_fs_mult_o == 7'h40; endproperty
	a_dfs: assert property (p_dfs) else $error("dac multiple wrong");
	property p_pre; (synth_mode_enable_o == $past(synth_mode_enable_o) && prescaler_ratio_sel_o == $past(prescaler_ratio_sel_o))[*2] |-> prescaler_ratio_o == pre_of(synth_mode_enable_o, prescaler_ratio_sel_o); endproperty
	a_pre: assert property (p_pre) else $error("prescaler ratio wrong");
	property p_one; pready_o |=> !pready_o; endproperty
	a_one: assert property (p_one) else $error("ready longer than one cycle");
	property p_ans; acc |=> pready_o; endproperty
	a_ans: assert property (p_ans) else $error("access not answered");
	property p_err; acc && (paddr_i[1:0] != 2'b00 || paddr_i[8:2] == 7'h04) |=> pready_o && pslverr_o; endproperty
	a_err: assert property (p_err) else $error("bad address not refused");
	property p_wo; acc && !pwrite_i && paddr_i == '0 |=> prdata_o == 32'h0 && !pslverr_o; endproperty
	a_wo: assert property (p_wo) else $error("write-only read not zero");
	property p_hi; pready_o |-> prdata_o[31:16] == 16'h0000; endproperty
	a_hi: assert property (p_hi) else $error("upper read half not zero");
	property p_quiet; !pready_o |-> prdata_o == 32'h0 && !pslverr_o; endproperty
	a_quiet: assert property (p_quiet) else $error("answer outside ready");
endmodule : acs_clock_regs_checker
bind acs_clock_regs acs_clock_regs_checker #(.APB_ADDR_W(APB_ADDR_W)) u_chk (.clk_i, .sys_rst_i,
	.ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pready_o, .prdata_o, .pslverr_o,
	.xtal_fs_mult_o, .dac_div_ratio_o, .dac_fs_mult_o, .synth_mode_enable_o,
	.prescaler_ratio_sel_o, .prescaler_ratio_o);

// File: tb/acs_host.sv
// host-side apb master model for the clock-setting register block
`timescale 1ns/1ps
module acs_host (
	input  wire logic        clk_i,
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic [11:0]      paddr_o,
	output logic [31:0]      pwdata_o,
	input  wire logic        pready_i,
	input  wire logic [31:0] prdata_i,
	input  wire logic        pslverr_i
);
	// bus idle from time zero
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'h000;
		pwdata_o = 32'h0;
	end
	// one transfer; the answer is taken only at the edge that sees pready high
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e, output logic to);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= wr;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_i !== 1'b1 && n < 20);
		to = (pready_i !== 1'b1);
		r = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// released lines do not keep their last value
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask : xfer
endmodule : acs_host

// File: tb/testbench.sv
// self-checking bench for the clock-setting register block
`timescale 1ns/1ps
module testbench;
	import acs_pkg::*;
	typedef struct packed {logic [15:0] w; logic [9:0] fs; logic [3:0] dv; logic [10:0] pr;} acs_row_s;
	logic        clk_i, sys_rst_i, ce_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er, to;
	logic        recovered_clk_i, xtal_clk_i, synth_source_sel_o, synth_mode_enable_o;
	logic        prescaler_reserved_o, clock_output_source_sel_o, clock_output_pin_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd_v;
	logic [3:0]  pstrb_i, dac_div_ratio_o;
	logic [15:0] interp_status_i, digital_input_status_i, loop_status_i;
	logic [15:0] power_down_settings_o, volume_left_right_o, loop_coarse_ratio_o;
	logic [39:0] chan_status_left_i, chan_status_right_i;
	logic [1:0]  crystal_divider_sel_o;
	logic [9:0]  xtal_fs_mult_o;
	logic [6:0]  dac_fs_mult_o;
	logic [2:0]  prescaler_ratio_sel_o;
	logic [10:0] prescaler_ratio_o;
	int          n_mismatch, checks_done;
	// clock word, then crystal multiple, dac divider and prescaler it should give
	acs_row_s rows [8] = '{'{16'h0000, 10'h080, 4'h2, 11'h000}, '{16'h0101, 10'h100, 4'h4, 11'h024},
		'{16'h0285, 10'h180, 4'h6, 11'h271}, '{16'h038B, 10'h200, 4'h8, 11'h280},
		'{16'h000D, 10'h080, 4'h2, 11'h465}, '{16'h000C, 10'h080, 4'h2, 11'h000},
		'{16'h0011, 10'h080, 4'h2, 11'h000}, '{16'hFC7D, 10'h080, 4'h2, 11'h000}};
	logic [6:0] s_idx [10] = '{IDX_INTERP, IDX_DIGSTAT, IDX_LOOPST, IDX_DEVINFO, IDX_CS_L0,
		IDX_CS_L1, IDX_CS_L2, IDX_CS_R0, IDX_CS_R1, IDX_CS_R2};
	logic [15:0] s_exp [10] = '{16'h1357, 16'h2468, 16'h9ABC, 16'h0000, 16'hC3D4, 16'hA1B2,
		16'h005A, 16'h0718, 16'hE5F6, 16'h00C7};
	acs_clock_regs uut (.clk_i, .sys_rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .pstrb_i, .pready_o, .prdata_o, .pslverr_o, .interp_status_i,
		.digital_input_status_i, .loop_status_i, .chan_status_left_i, .chan_status_right_i,
		.recovered_clk_i, .xtal_clk_i, .crystal_divider_sel_o, .xtal_fs_mult_o, .dac_div_ratio_o,
		.dac_fs_mult_o, .synth_source_sel_o, .synth_mode_enable_o, .prescaler_ratio_sel_o,
		.prescaler_ratio_o, .prescaler_reserved_o, .clock_output_source_sel_o,
		.clock_output_pin_o, .serial_output_settings_o(), .serial_input_settings_o(),
		.power_down_settings_o, .volume_left_right_o, .sound_feature_tone_o(),
		.deemphasis_mute_o(), .dac_source_clock_o(), .digital_input_settings_o(),
		.supplemental_settings_o(), .loop_coarse_ratio_o);
	acs_host host (.clk_i, .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i),
		.paddr_o(paddr_i), .pwdata_o(pwdata_i), .pready_i(pready_o), .prdata_i(prdata_o),
		.pslverr_i(pslverr_o));
	////////////////////////////////////////
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			n_mismatch++;
		end
	endtask : chk
	// a hung bus ends the run at once
	task bus(input logic wr, input logic [6:0] idx, input logic [15:0] d, input logic [1:0] lo);
		host.xfer(wr, {3'h0, idx, lo}, {16'h0000, d}, rd_v, er, to);
		if (to) begin
			$display("ERROR bus answer expected 1 seen 0");
			n_mismatch++;
			stop_test();
		end
	endtask : bus
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// table rows, then reset and refusal cases
	initial begin
		{sys_rst_i, ce_i, pstrb_i, xtal_clk_i, recovered_clk_i} = 8'hFC;
		{interp_status_i, digital_input_status_i, loop_status_i} = '0;
		{chan_status_left_i, chan_status_right_i} = '0;
		n_mismatch = 0;
		checks_done = 0;
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			xtal_clk_i <= i[0];
			recovered_clk_i <= !i[0];
			bus(1'b1, IDX_CLOCK, rows[i].w, 2'b00);
			repeat (8) @(posedge clk_i);
			chk("divider sel", rows[i].w[9:8], crystal_divider_sel_o);
			chk("crystal fs", rows[i].fs, xtal_fs_mult_o);
			chk("dac ratio", rows[i].dv, dac_div_ratio_o);
			chk("synth source", rows[i].w[7], synth_source_sel_o);
			chk("prescale code", rows[i].w[4:2], prescaler_ratio_sel_o);
			chk("prescale", rows[i].pr, prescaler_ratio_o);
			chk("prescale rsvd", rows[i].w[4], prescaler_reserved_o);
			chk("out source", rows[i].w[1], clock_output_source_sel_o);
			chk("out pin", rows[i].w[1] ? i[0] : !i[0], clock_output_pin_o);
			chk("synth enable", rows[i].w[0], synth_mode_enable_o);
			$display("row %0d done", i);
		end
		bus(1'b1, IDX_CLOCK, 16'h038B, 2'b00);
		bus(1'b1, IDX_POWER, 16'h0000, 2'b00);
		bus(1'b1, IDX_VOLUME, 16'hFFFF, 2'b00);
		bus(1'b1, IDX_COARSE, 16'h1234, 2'b00);
		bus(1'b1, IDX_SWRST, 16'h5555, 2'b00);
		repeat (3) @(posedge clk_i);
		chk("soft clock", 32'h080, xtal_fs_mult_o);
		chk("soft power", 32'h2013, power_down_settings_o);
		chk("soft volume", 32'h0, volume_left_right_o);
		chk("soft coarse", 32'h0, loop_coarse_ratio_o);
		$display("soft reset test done");
		bus(1'b1, IDX_CLOCK, 16'h038B, 2'b00);
		sys_rst_i <= 1'b1;
		@(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		chk("reset fields", 32'h0, {prescaler_ratio_sel_o, crystal_divider_sel_o, synth_source_sel_o, clock_output_source_sel_o, synth_mode_enable_o});
		chk("reset dac", 32'h2, dac_div_ratio_o);
		chk("reset power", 32'h2013, power_down_settings_o);
		$display("reset test done");
		{interp_status_i, digital_input_status_i, loop_status_i} <= 48'h1357_2468_9ABC;
		chan_status_left_i <= 40'h5A_A1B2_C3D4;
		chan_status_right_i <= 40'hC7_E5F6_0718;
		repeat (6) @(posedge clk_i);
		for (int j = 0; j < 10; j++) begin
			bus(1'b0, s_idx[j], 16'h0000, 2'b00);
			chk("status read", {16'h0000, s_exp[j]}, rd_v);
			chk("status err", 32'h0, er);
		end
		$display("status test done");
		bus(1'b1, IDX_CLOCK, 16'h0101, 2'b00);
		bus(1'b1, IDX_INTERP, 16'hFFFF, 2'b00);
		chk("status write err", 32'h0, er);
		bus(1'b1, 7'h04, 16'h038B, 2'b00);
		chk("unmapped err", 32'h1, er);
		bus(1'b1, IDX_CLOCK, 16'h038B, 2'b10);
		chk("misaligned err", 32'h1, er);
		bus(1'b0, IDX_CLOCK, 16'h0000, 2'b00);
		chk("write-only read", 32'h0, {rd_v[31:1], rd_v[0] | er});
		repeat (3) @(posedge clk_i);
		chk("clock kept", 32'h100, xtal_fs_mult_o);
		$display("refusal test done");
		// only byte lane 0 written: divider bits in lane 1 must stay
		pstrb_i <= 4'h1;
		bus(1'b1, IDX_CLOCK, 16'h038C, 2'b00);
		pstrb_i <= 4'hF;
		repeat (3) @(posedge clk_i);
		chk("lane1 kept", 32'h100, xtal_fs_mult_o);
		chk("lane0 source", 32'h1, synth_source_sel_o);
		chk("lane0 prescale", 32'h3, prescaler_ratio_sel_o);
		$display("strobe test done");
		// clock enable low freezes the pin path, high lets it follow again
		ce_i <= 1'b0;
		recovered_clk_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk("frozen pin", 32'h0, clock_output_pin_o);
		ce_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk("running pin", 32'h1, clock_output_pin_o);
		$display("clock enable test done");
		stop_test();
	end
endmodule : testbench
